// ===== hw/insn_decode_pkg.sv
`default_nettype none
package insn_decode_pkg;
    // Instruction word layout.
    localparam int INSN_W = 14;
    localparam int FADDR_W = 7;
    localparam int BITSEL_W = 3;
    localparam int LIT8_W = 8;
    localparam int LIT11_W = 11;
    localparam int DEST_POS = 7;
    localparam int BITSEL_LSB = 7;
    localparam int CLASS_MSB = 13;
    localparam int CLASS_LSB = 12;
    localparam logic [6:0] FADDR_MIN = 7'h00;
    localparam logic [6:0] FADDR_MAX = 7'h7f;
    // Instruction classes held in bits 13:12.
    localparam logic [1:0] CLASS_BYTE = 2'h0;
    localparam logic [1:0] CLASS_BIT = 2'h1;
    localparam logic [1:0] CLASS_JUMP = 2'h2;
    localparam logic [1:0] CLASS_LIT = 2'h3;
    // Bit-oriented sub-ops in bits 11:10; 2 and 3 are the conditional skips.
    localparam logic [1:0] BIT_SKIP_CLR = 2'h2;
    localparam logic [1:0] BIT_SKIP_SET = 2'h3;
    // Timing.
    localparam int PHASES = 4;
    localparam logic [1:0] PHASE_LAST = 2'h3;
    localparam logic [13:0] NOP_WORD = 14'h0000;
    typedef enum logic [1:0] {
        ST_EXEC = 2'b00,
        ST_FLUSH = 2'b01
    } cyc_state_type;
endpackage
`default_nettype wire

// ===== hw/insn_phase_gen.sv
`default_nettype none
module insn_phase_gen
    import insn_decode_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    output logic [1:0] o_phase,
    output logic o_cycle_end
);
    logic [1:0] phase_ff;
    logic [1:0] nxt_phase;

    assign nxt_phase = phase_ff + 2'h1;

    // One instruction cycle is four clock periods.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            phase_ff <= 2'h0;
        end else begin
            phase_ff <= nxt_phase;
        end
    end

    assign o_phase = phase_ff;
    assign o_cycle_end = (phase_ff == PHASE_LAST);
endmodule
`default_nettype wire

// ===== hw/instruction_field_decode_timing.sv
// Summary of operation
// - Register operand is a 7-bit file address, 0x00 to 0x7F.
// - Destination bit 0 writes accumulator, 1 writes the addressed file register.
// - Bit-oriented ops select exactly one of eight bits by the bit field.
// - Don't-care opcode bits never change the decode.
// - Ordinary instructions complete in one instruction cycle.
// - True skips and PC changes take two cycles, second one a no-op.
// - An instruction cycle is four consecutive oscillator periods.
// - Instructions are fetched and decoded as 14-bit words.
// - Literal is 8 bits or 11 bits depending on instruction class.
`default_nettype none
module instruction_field_decode_timing
    import insn_decode_pkg::*;
(
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic [insn_decode_pkg::INSN_W-1:0] i_insn,
    input wire logic i_skip_cond,
    output logic o_fetch,
    output logic o_exec_valid,
    output logic o_flush,
    output logic [insn_decode_pkg::FADDR_W-1:0] o_faddr,
    output logic o_dest_file,
    output logic o_dest_acc,
    output logic [7:0] o_bit_mask,
    output logic [insn_decode_pkg::LIT8_W-1:0] o_lit8,
    output logic [insn_decode_pkg::LIT11_W-1:0] o_lit11,
    output logic o_lit11_sel,
    output logic o_pc_load
);
    import insn_decode_pkg::*;

    // ------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------
    // The slicing below assumes a two-bit class on top of an 11-bit literal, and a
    // three-bit selector spanning the eight bits of one file register. Any other
    // layout would silently misroute operand bits, so it is refused here.
    generate
        if ((INSN_W != CLASS_MSB + 1) || (LIT11_W != CLASS_LSB - 1)) begin : g_bad_layout
            $error("instruction layout constants do not fit the decoder");
        end
        if (((1 << BITSEL_W) != 8) || (FADDR_W != 7) || (LIT8_W != 8)) begin : g_bad_fields
            $error("operand field constants do not fit the decoder");
        end
    endgenerate

    // ------------------------------------------------------------
    // Cycle timing
    // ------------------------------------------------------------
    logic [1:0] phase;
    logic cycle_end;

    insn_phase_gen u_phase (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .o_phase(phase),
        .o_cycle_end(cycle_end)
    );

    // ------------------------------------------------------------
    // Field decode
    // ------------------------------------------------------------
    // The word is latched at the start of its cycle; the latch holds 14 bits.
    logic [INSN_W-1:0] insn_ff;
    cyc_state_type state_ff;
    cyc_state_type nxt_state;
    wire [1:0] cls = insn_ff[CLASS_MSB:CLASS_LSB];
    wire [1:0] bit_op = insn_ff[11:10];
    wire [FADDR_W-1:0] faddr = insn_ff[FADDR_W-1:0];
    wire dest_bit = insn_ff[DEST_POS];
    wire [BITSEL_W-1:0] bitsel = insn_ff[BITSEL_LSB +: BITSEL_W];
    // Only the class and sub-op bits drive control; any other bit, including the
    // don't-care positions, reaches nothing but operand fields.
    wire is_byte = (cls == CLASS_BYTE);
    wire is_bit = (cls == CLASS_BIT);
    wire is_jump = (cls == CLASS_JUMP);
    wire is_lit = (cls == CLASS_LIT);
    wire is_skip = is_bit && ((bit_op == BIT_SKIP_CLR) || (bit_op == BIT_SKIP_SET));
    wire two_cycle = is_jump || (is_skip && i_skip_cond);
    wire in_flush = (state_ff == ST_FLUSH);

    // A two-cycle instruction is followed by a flush cycle; others return to exec.
    assign nxt_state = (!in_flush && two_cycle) ? ST_FLUSH : ST_EXEC;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic exec_valid_ff;
    logic flush_ff;
    logic fetch_ff;
    logic [FADDR_W-1:0] faddr_ff;
    logic dest_file_ff;
    logic dest_acc_ff;
    logic [7:0] bit_mask_ff;
    logic [LIT8_W-1:0] lit8_ff;
    logic [LIT11_W-1:0] lit11_ff;
    logic lit11_sel_ff;
    logic pc_load_ff;
    logic [7:0] nxt_mask;

    // One-hot bit target, built per bit.
    genvar gi;
    generate
        for (gi = 0; gi < 8; gi++) begin : g_mask
            assign nxt_mask[gi] = is_bit && !in_flush && (bitsel == BITSEL_W'(gi));
        end
    endgenerate

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            insn_ff <= NOP_WORD;
            state_ff <= ST_EXEC;
        end else if (cycle_end) begin
            // The word fetched during a flush cycle replaces the discarded one.
            insn_ff <= i_insn;
            state_ff <= nxt_state;
        end
    end

    // ------------------------------------------------------------
    // Output registers
    // ------------------------------------------------------------
    // Decoded outputs change at the start of phase 1 and hold for four clocks, into phase 0 of the next cycle. Each group has
    // its own short register so the reset value sits beside its update.
    logic nxt_fetch;
    logic nxt_dest_file;
    logic nxt_dest_acc;
    logic nxt_pc_load;

    // The strobe stands for the clock before the latch edge, so the memory only
    // has to drive the word while it is actually sampled.
    assign nxt_fetch = (phase == PHASE_LAST) ? 1'b0 : (phase == 2'h2);
    // Destination strobes only for byte ops outside a flush.
    assign nxt_dest_file = is_byte && !in_flush && dest_bit;
    assign nxt_dest_acc = is_byte && !in_flush && !dest_bit;
    // A discarded jump must not load the counter a second time.
    assign nxt_pc_load = is_jump && !in_flush;

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            fetch_ff <= 1'b0;
        end else begin
            fetch_ff <= nxt_fetch;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            exec_valid_ff <= 1'b0;
            flush_ff <= 1'b0;
        end else begin
            exec_valid_ff <= !in_flush;
            flush_ff <= in_flush;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            faddr_ff <= FADDR_MIN;
        end else begin
            faddr_ff <= faddr;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            dest_file_ff <= 1'b0;
            dest_acc_ff <= 1'b0;
        end else begin
            dest_file_ff <= nxt_dest_file;
            dest_acc_ff <= nxt_dest_acc;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            bit_mask_ff <= 8'h00;
        end else begin
            bit_mask_ff <= nxt_mask;
        end
    end

    // Both literal widths are always presented; the select tells the datapath
    // which one the current class means, so no wide multiplexer is needed here.
    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            lit8_ff <= 8'h00;
        end else begin
            lit8_ff <= insn_ff[LIT8_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            lit11_ff <= 11'h000;
            lit11_sel_ff <= 1'b0;
        end else begin
            lit11_ff <= insn_ff[LIT11_W-1:0];
            lit11_sel_ff <= is_jump;
        end
    end

    always_ff @(posedge i_sys_clk) begin
        if (i_rst) begin
            pc_load_ff <= 1'b0;
        end else begin
            pc_load_ff <= nxt_pc_load;
        end
    end

    assign o_fetch = fetch_ff;
    assign o_exec_valid = exec_valid_ff;
    assign o_flush = flush_ff;
    assign o_faddr = faddr_ff;
    assign o_dest_file = dest_file_ff;
    assign o_dest_acc = dest_acc_ff;
    assign o_bit_mask = bit_mask_ff;
    assign o_lit8 = lit8_ff;
    assign o_lit11 = lit11_ff;
    assign o_lit11_sel = lit11_sel_ff;
    assign o_pc_load = pc_load_ff;

    wire unused_lit = is_lit;
endmodule
`default_nettype wire

// ===== test/insn_mem_model.sv
`default_nettype none
module insn_mem_model (
    input wire logic i_fetch,
    input wire logic [13:0] i_word,
    output logic [13:0] o_insn
);
    timeunit 1ns;
    timeprecision 1ps;
    // Off the fetch slot the bus shows the inverse word, so a late latch is caught.
    assign o_insn = i_fetch ? i_word : ~i_word;
endmodule
`default_nettype wire

// ===== test/insn_decode_asserts.sv
`default_nettype none
module insn_decode_asserts (
    input wire logic i_sys_clk,
    input wire logic i_rst,
    input wire logic o_fetch,
    input wire logic o_exec_valid,
    input wire logic o_flush,
    input wire logic [6:0] o_faddr,
    input wire logic o_dest_file,
    input wire logic o_dest_acc,
    input wire logic [7:0] o_bit_mask,
    input wire logic [7:0] o_lit8,
    input wire logic [10:0] o_lit11,
    input wire logic o_lit11_sel,
    input wire logic o_pc_load
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge i_sys_clk); endclocking
    default disable iff (i_rst);
    AST_FETCH: assert property (o_fetch |=> !o_fetch [*3] ##1 o_fetch)
        else $error("fetch period wrong");
    AST_PC_FLUSH: assert property ($rose(o_pc_load) |-> o_pc_load [*4] ##1 o_flush [*4])
        else $error("jump not followed by flush");
    AST_FLUSH_LEN: assert property ($rose(o_flush) |-> o_flush [*4] ##1 !o_flush)
        else $error("flush length wrong");
    AST_QUIET: assert property (o_flush |-> !(o_exec_valid | o_pc_load | o_dest_file | o_dest_acc | (|o_bit_mask)))
        else $error("flush has effects");
    AST_DEST: assert property ((o_dest_file | o_dest_acc) |-> o_dest_file != o_dest_acc && o_dest_file == o_lit8[7])
        else $error("destination wrong");
    AST_MASK: assert property (|o_bit_mask |-> o_bit_mask == 8'h01 << o_lit11[9:7] && !o_dest_file)
        else $error("bit mask wrong");
    AST_FIELDS: assert property (o_exec_valid |-> o_lit8 == o_lit11[7:0] && o_faddr == o_lit8[6:0])
        else $error("fields disagree");
    AST_SEL_PC: assert property ((o_exec_valid | o_pc_load) |-> o_exec_valid && o_lit11_sel == o_pc_load)
        else $error("literal width select wrong");
endmodule
bind instruction_field_decode_timing insn_decode_asserts chk_u (
    .i_sys_clk(i_sys_clk),
    .i_rst(i_rst),
    .o_fetch(o_fetch),
    .o_exec_valid(o_exec_valid),
    .o_flush(o_flush),
    .o_faddr(o_faddr),
    .o_dest_file(o_dest_file),
    .o_dest_acc(o_dest_acc),
    .o_bit_mask(o_bit_mask),
    .o_lit8(o_lit8),
    .o_lit11(o_lit11),
    .o_lit11_sel(o_lit11_sel),
    .o_pc_load(o_pc_load)
);
`default_nettype wire

// ===== test/instruction_field_decode_timing_tb_top.sv
`default_nettype none
module instruction_field_decode_timing_tb_top import insn_decode_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic i_sys_clk = 0, i_rst = 1, i_skip_cond = 0, pj = 0, ps = 0;
    logic o_fetch, o_exec_valid, o_flush, o_dest_file, o_dest_acc, o_lit11_sel, o_pc_load;
    logic [6:0] o_faddr;
    logic [7:0] o_bit_mask, o_lit8;
    logic [10:0] o_lit11;
    logic [13:0] word = 14'h0000, i_insn;
    int errors = 0, checked = 0;
    instruction_field_decode_timing dut_u (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_insn(i_insn),
        .i_skip_cond(i_skip_cond),
        .o_fetch(o_fetch),
        .o_exec_valid(o_exec_valid),
        .o_flush(o_flush),
        .o_faddr(o_faddr),
        .o_dest_file(o_dest_file),
        .o_dest_acc(o_dest_acc),
        .o_bit_mask(o_bit_mask),
        .o_lit8(o_lit8),
        .o_lit11(o_lit11),
        .o_lit11_sel(o_lit11_sel),
        .o_pc_load(o_pc_load)
    );
    insn_mem_model mem_u (.i_fetch(o_fetch), .i_word(word), .o_insn(i_insn));
    task automatic check(input logic [39:0] seen, input logic [39:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED decode exp %h seen %h", exp, seen);
        end
    endtask
    task automatic tally_and_finish();
        if (errors == 0 && checked > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    task automatic run(input logic [13:0] w, input logic s);
        logic [1:0] c;
        logic fl;
        logic [39:0] m, e;
        c = w[13:12];
        fl = pj | (ps & s);
        e = fl ? 40'h40_0000_0000 : {2'b10, w[6:0], c == 0 && w[7], c == 0 && !w[7],
            c == 1 ? 8'h01 << w[9:7] : 8'h00, w[7:0], w[10:0], c == 2, c == 2};
        m = fl ? {2'b11, 7'h00, 10'h3ff, 19'h0_0000, 2'b01} : '1;
        pj = !fl && c == CLASS_JUMP;
        ps = !fl && c == CLASS_BIT && w[11];
        @(negedge i_sys_clk);
        while (!o_fetch) @(negedge i_sys_clk);
        word = w;
        i_skip_cond = s;
        repeat (2) @(negedge i_sys_clk);
        check(m & {o_exec_valid, o_flush, o_faddr, o_dest_file, o_dest_acc, o_bit_mask,
            o_lit8, o_lit11, o_lit11_sel, o_pc_load}, m & e);
    endtask
    initial forever #10 i_sys_clk = ~i_sys_clk;
    initial begin
        #200000;
        errors++;
        tally_and_finish();
    end
    initial begin
        logic [14:0] cases [8] = '{15'h00ff, 15'h0000, 15'h1f85, 15'h7fff,
            15'h2abc, 15'h2123, 15'h5b00, 15'h3abc};
        void'($urandom(23816));
        repeat (6) @(negedge i_sys_clk);
        i_rst = 0;
        foreach (cases[i]) run(cases[i][13:0], cases[i][14]);
        repeat (300) run(14'($urandom), 1'($urandom));
        tally_and_finish();
    end
endmodule
`default_nettype wire
